// >>> design/serial_flash_boot_command_decoder.v
// Serial boot command decoder with its receive FIFO
// What this block does
// - First received byte of a sequence is command
// - Page read: FF, middle address, high address
// - Page read returns 256 bytes, falling edge
// - Page program: 41, middle address, high address
// - Take 256 bytes, then write page automatically
// - Busy falls when ready after page program
// - Erase all needs A7 then D0 confirm
// - Busy falls when erase all completes
// - Command 70 returns two status bytes
// - Command 50 clears error flags, busy falls
// - Download: FA, size low, high, checksum, data
// - Checksum is sum of data bytes
// - Run downloaded program only on checksum match
// - Command FB returns eight version characters
// - Command FC returns one boot area page
// - ID check: F5, address, length, ID bytes
// - Unverified ID allows only 70, F5, FB
// - Blank flash accepts every command
// - Bytes are eight bits, LSB first
// - Sample on rising, shift out on falling
// - Busy high while transferring or operating
// - Flash status reads 80 after reset
`timescale 1ns/100ps
`default_nettype none
`include "sfb_cmd_regs.vh"

// ------------------------------------------------------------
// Receive byte FIFO
// ------------------------------------------------------------
module sfb_rx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_clk,
  input  wire             i_reset_n,
  input  wire             i_valid,
  output wire             o_ready,
  input  wire [WIDTH-1:0] i_data,
  output wire             o_valid,
  input  wire             i_ready,
  output wire [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  assign o_ready = (count_q != DEPTH[AW:0]);
  assign o_valid = (count_q != {(AW+1){1'b0}});
  assign o_data  = mem_q[rd_ptr_q];
  assign push    = i_valid & o_ready;
  assign pop     = i_ready & o_valid;

  // Storage write
  always @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_data;
    end
  end

  // Pointers and fill level
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // sfb_rx_fifo

// ------------------------------------------------------------
// Command decoder top
// ------------------------------------------------------------
module serial_flash_boot_command_decoder #(
  parameter [63:0] VERSION_TEXT = "VER.0.01", // Arbitrary text
  parameter        FIFO_DEPTH   = 8
) (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_sclk,
  input  wire        i_rxd,
  output wire        o_txd,
  output wire        o_handshake_wait_line,
  input  wire        i_flash_blank,
  output wire [15:0] o_mem_addr,
  output wire        o_mem_boot_sel,
  output wire        o_mem_rd,
  input  wire [7:0]  i_mem_rdata,
  output wire        o_mem_wr,
  output wire [7:0]  o_mem_wdata,
  input  wire        i_mem_wr_ready,
  output wire        o_page_commit,
  output wire        o_erase_start,
  input  wire        i_flash_done,
  input  wire        i_flash_err,
  output wire        o_ram_wr,
  output wire [15:0] o_ram_addr,
  output wire [7:0]  o_ram_wdata,
  output wire        o_run_download,
  output wire [7:0]  o_flash_op_status,
  output wire [7:0]  o_link_check_status
);
  localparam [3:0] S_CMD    = 4'h0;
  localparam [3:0] S_HDR    = 4'h1;
  localparam [3:0] S_ERCONF = 4'h2;
  localparam [3:0] S_ERASE  = 4'h3;
  localparam [3:0] S_PROG   = 4'h4;
  localparam [3:0] S_PWAIT  = 4'h5;
  localparam [3:0] S_DL     = 4'h6;
  localparam [3:0] S_IDDATA = 4'h7;
  localparam [3:0] S_IDCMP  = 4'h8;
  localparam [3:0] S_RDLAT  = 4'h9;
  localparam [3:0] S_TXWAIT = 4'hA;
  localparam [3:0] S_NEXT   = 4'hB;

  // Header length for each command carrying one
  function [2:0] hdr_len;
    input [7:0] cmd;
    begin
      case (cmd)
        `CMD_DOWNLOAD: hdr_len = `HDR_LEN_DOWNLOAD;
        `CMD_ID_CHECK: hdr_len = `HDR_LEN_ID;
        default:       hdr_len = `HDR_LEN_ADDR;
      endcase
    end
  endfunction

  // ----------------------------------------------------------
  // Link pin synchronisers and serial engine
  // ----------------------------------------------------------
  reg       sclk_s1_q, sclk_s2_q, sclk_s3_q;
  reg       rxd_s1_q, rxd_s2_q;
  reg [7:0] rx_sh_q;
  reg [2:0] bit_cnt_q;
  reg       active_q;
  reg       tx_mode_q;
  reg [6:0] tx_sh_q;
  reg       txd_q;
  reg       tx_done_q;
  reg       tx_load_q;
  reg [7:0] tx_byte_q;
  wire      sclk_rise = sclk_s2_q & ~sclk_s3_q;
  wire      sclk_fall = ~sclk_s2_q & sclk_s3_q;
  wire      byte_end  = sclk_rise & (bit_cnt_q == 3'h7);
  wire      rx_push   = byte_end & ~tx_mode_q;

  // Two-stage synchronisers for clock and data pins
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      sclk_s1_q <= 1'b1;
      sclk_s2_q <= 1'b1;
      sclk_s3_q <= 1'b1;
      rxd_s1_q  <= 1'b1;
      rxd_s2_q  <= 1'b1;
    end else begin
      sclk_s1_q <= i_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      rxd_s1_q  <= i_rxd;
      rxd_s2_q  <= rxd_s1_q;
    end
  end

  // Bit shifting, LSB first in both directions
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      rx_sh_q   <= 8'h00;
      bit_cnt_q <= 3'h0;
      active_q  <= 1'b0;
      tx_mode_q <= 1'b0;
      tx_sh_q   <= 7'h00;
      txd_q     <= 1'b1;
      tx_done_q <= 1'b0;
    end else begin
      tx_done_q <= byte_end & tx_mode_q;
      if (sclk_rise) begin
        rx_sh_q   <= {rxd_s2_q, rx_sh_q[7:1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        active_q  <= ~byte_end;
      end
      if (byte_end) begin
        tx_mode_q <= 1'b0;
      end else if (tx_load_q) begin
        tx_mode_q <= 1'b1;
        txd_q     <= tx_byte_q[0];
        tx_sh_q   <= tx_byte_q[7:1];
      end else if (sclk_fall && tx_mode_q && bit_cnt_q != 3'h0) begin // Bit 0 stands over first fall
        txd_q   <= tx_sh_q[0];
        tx_sh_q <= {1'b0, tx_sh_q[6:1]};
      end
    end
  end

  // ----------------------------------------------------------
  // Receive FIFO between engine and decoder
  // ----------------------------------------------------------
  wire       fifo_in_ready;
  wire       fifo_valid;
  wire [7:0] fifo_data;
  reg        fifo_pop;

  sfb_rx_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_rx_fifo (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_valid   (rx_push),
    .o_ready   (fifo_in_ready),
    .i_data    ({rxd_s2_q, rx_sh_q[7:1]}),
    .o_valid   (fifo_valid),
    .i_ready   (fifo_pop),
    .o_data    (fifo_data)
  );

  // ----------------------------------------------------------
  // Command decoder
  // ----------------------------------------------------------
  reg [3:0]  state_q;
  reg [7:0]  cmd_q;
  reg [2:0]  hdr_q;
  reg [8:0]  cnt_q;
  reg [7:0]  addr_mid_q;
  reg [15:0] id_addr_q;
  reg [7:0]  id_len_q;
  reg        id_fail_q;
  reg [7:0]  hold_q;
  reg [15:0] size_q;
  reg [7:0]  csum_q;
  reg [7:0]  sum_q;
  reg        prog_err_q, erase_err_q;
  reg        boot_upd_q, csum_ok_q;
  reg [1:0]  id_state_q;
  reg [15:0] mem_addr_q;
  reg        mem_boot_q, mem_rd_q, mem_wr_q;
  reg [7:0]  mem_wdata_q;
  reg        commit_q, erase_start_q;
  reg        ram_wr_q, run_q;
  reg [15:0] ram_addr_q;
  reg [7:0]  ram_wdata_q;
  reg        busy_q;
  reg        wait_ok;
  reg [8:0]  rx_cnt_q;
  wire       unlocked = (id_state_q == `ID_VERIFIED) | i_flash_blank;
  wire [7:0] flash_op_status      = {~(state_q == S_PWAIT || state_q == S_ERASE), 1'b0,
                         erase_err_q, prog_err_q, 4'h0};
  wire [7:0] link_check_status     = {boot_upd_q, 2'b00, csum_ok_q, id_state_q, 2'b00};
  wire [7:0] sum_next = sum_q + fifo_data;

  // Decoder takes a byte when waiting for one
  always @* begin
    case (state_q)
      S_CMD, S_HDR, S_ERCONF, S_DL, S_IDDATA: fifo_pop = fifo_valid;
      S_PROG:  fifo_pop = fifo_valid & i_mem_wr_ready;
      default: fifo_pop = 1'b0;
    endcase
  end

  // Ready for the next byte from the programmer
  always @* begin
    case (state_q)
      S_CMD, S_HDR, S_ERCONF, S_DL, S_IDDATA: wait_ok = ~fifo_valid;
      S_PROG:   wait_ok = (rx_cnt_q != `PAGE_BYTES);
      S_TXWAIT: wait_ok = tx_mode_q & ~tx_load_q;
      default:  wait_ok = 1'b0;
    endcase
  end

  // Page bytes received so far; busy holds once the whole page is in
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      rx_cnt_q <= 9'h000;
    end else if (state_q != S_PROG) begin
      rx_cnt_q <= 9'h000;
    end else if (rx_push) begin
      rx_cnt_q <= rx_cnt_q + 9'h001;
    end
  end

  // Busy line
  always @(posedge i_clk) begin
    if (!i_reset_n) busy_q <= 1'b0;
    else busy_q <= active_q | sclk_rise | ~fifo_in_ready | ~wait_ok;
  end

  // Sequence state machine
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= S_CMD;        cmd_q <= 8'h00;       hdr_q <= 3'h0;
      cnt_q <= 9'h000;         addr_mid_q <= 8'h00;  id_addr_q <= 16'h0000;
      id_len_q <= 8'h00;       id_fail_q <= 1'b0;    hold_q <= 8'h00;
      size_q <= 16'h0000;      csum_q <= 8'h00;      sum_q <= 8'h00;
      prog_err_q <= 1'b0;      erase_err_q <= 1'b0;
      boot_upd_q <= 1'b0;      csum_ok_q <= 1'b0;    id_state_q <= `ID_NOT_VERIFIED;
      mem_addr_q <= 16'h0000;  mem_boot_q <= 1'b0;   mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;        mem_wdata_q <= 8'h00; commit_q <= 1'b0;
      erase_start_q <= 1'b0;   ram_wr_q <= 1'b0;     run_q <= 1'b0;
      ram_addr_q <= 16'h0000;  ram_wdata_q <= 8'h00;
      tx_load_q <= 1'b0;       tx_byte_q <= 8'h00;
    end else begin
      mem_rd_q      <= 1'b0;
      mem_wr_q      <= 1'b0;
      commit_q      <= 1'b0;
      erase_start_q <= 1'b0;
      ram_wr_q      <= 1'b0;
      run_q         <= 1'b0;
      tx_load_q     <= 1'b0;
      case (state_q)
        S_CMD: if (fifo_pop) begin
          cmd_q <= fifo_data;
          hdr_q <= 3'h0;
          cnt_q <= 9'h000;
          case (fifo_data)
            `CMD_READ_STATUS, `CMD_VERSION: state_q <= S_NEXT;
            `CMD_ID_CHECK: state_q <= S_HDR;
            `CMD_PAGE_READ, `CMD_BOOT_READ, `CMD_PAGE_PROG, `CMD_DOWNLOAD:
              if (unlocked) state_q <= S_HDR;
            `CMD_ERASE_ALL: if (unlocked) state_q <= S_ERCONF;
            `CMD_CLEAR_STATUS: if (unlocked) begin
              prog_err_q  <= 1'b0;
              erase_err_q <= 1'b0;
              boot_upd_q  <= 1'b0;
              csum_ok_q   <= 1'b0;
            end
            default: state_q <= S_CMD;
          endcase
        end
        S_HDR: if (fifo_pop) begin
          hdr_q <= hdr_q + 3'h1;
          case (cmd_q)
            `CMD_DOWNLOAD: begin
              if (hdr_q == 3'h0) size_q[7:0]  <= fifo_data;
              if (hdr_q == 3'h1) size_q[15:8] <= fifo_data;
              if (hdr_q == 3'h2) csum_q       <= fifo_data;
            end
            `CMD_ID_CHECK: begin
              if (hdr_q == 3'h0) id_addr_q[7:0]  <= fifo_data;
              if (hdr_q == 3'h1) id_addr_q[15:8] <= fifo_data;
              if (hdr_q == 3'h3) id_len_q        <= fifo_data;
            end
            default: if (hdr_q == 3'h0) addr_mid_q <= fifo_data;
          endcase
          if (hdr_q == hdr_len(cmd_q) - 3'h1) begin
            sum_q      <= 8'h00;
            id_fail_q  <= 1'b0;
            ram_addr_q <= 16'h0000;
            case (cmd_q)
              `CMD_PAGE_PROG: state_q <= S_PROG;
              `CMD_DOWNLOAD:  state_q <= (size_q == 16'h0000) ? S_CMD : S_DL;
              `CMD_ID_CHECK:  state_q <= (fifo_data == 8'h00) ? S_CMD : S_IDDATA;
              default:        state_q <= S_NEXT;
            endcase
          end
        end
        S_PROG: if (fifo_pop) begin
          mem_wr_q    <= 1'b1;
          mem_boot_q  <= 1'b0;
          mem_addr_q  <= {addr_mid_q, cnt_q[7:0]};
          mem_wdata_q <= fifo_data;
          cnt_q       <= cnt_q + 9'h001;
          if (cnt_q == `PAGE_BYTES - 9'h001) begin
            commit_q <= 1'b1;
            state_q  <= S_PWAIT;
          end
        end
        S_PWAIT: if (i_flash_done) begin
          prog_err_q <= i_flash_err;
          state_q    <= S_CMD;
        end
        S_ERCONF: if (fifo_pop) begin
          erase_start_q <= (fifo_data == `CMD_ERASE_CONFIRM);
          state_q <= (fifo_data == `CMD_ERASE_CONFIRM) ? S_ERASE : S_CMD;
        end
        S_ERASE: if (i_flash_done) begin
          erase_err_q <= i_flash_err;
          state_q     <= S_CMD;
        end
        S_DL: if (fifo_pop) begin
          ram_wr_q    <= 1'b1;
          ram_addr_q  <= ram_addr_q + 16'h0001;
          ram_wdata_q <= fifo_data;
          sum_q       <= sum_next;
          size_q      <= size_q - 16'h0001;
          if (size_q == 16'h0001) begin
            csum_ok_q  <= (sum_next == csum_q);
            boot_upd_q <= (sum_next == csum_q);
            run_q      <= (sum_next == csum_q);
            state_q    <= S_CMD;
          end
        end
        S_IDDATA: if (fifo_pop) begin
          hold_q     <= fifo_data;
          mem_rd_q   <= 1'b1;
          mem_boot_q <= 1'b0;
          mem_addr_q <= id_addr_q;
          state_q    <= S_IDCMP;
        end
        S_IDCMP: begin
          id_addr_q <= id_addr_q + 16'h0001;
          id_len_q  <= id_len_q - 8'h01;
          id_fail_q <= id_fail_q | (i_mem_rdata != hold_q);
          if (id_len_q == 8'h01) begin
            id_state_q <= (id_fail_q || i_mem_rdata != hold_q) ? `ID_MISMATCH : `ID_VERIFIED;
            state_q    <= S_CMD;
          end else begin
            state_q <= S_IDDATA;
          end
        end
        S_NEXT: begin
          case (cmd_q)
            `CMD_READ_STATUS: begin
              tx_load_q <= 1'b1;
              tx_byte_q <= (cnt_q == 9'h000) ? flash_op_status : link_check_status;
              state_q   <= S_TXWAIT;
            end
            `CMD_VERSION: begin
              tx_load_q <= 1'b1;
              tx_byte_q <= VERSION_TEXT[8'd63 - {cnt_q[4:0], 3'b000} -: 8];
              state_q   <= S_TXWAIT;
            end
            default: begin
              mem_rd_q   <= 1'b1;
              mem_boot_q <= (cmd_q == `CMD_BOOT_READ);
              mem_addr_q <= {addr_mid_q, cnt_q[7:0]};
              state_q    <= S_RDLAT;
            end
          endcase
        end
        S_RDLAT: begin
          tx_load_q <= 1'b1;
          tx_byte_q <= i_mem_rdata;
          state_q   <= S_TXWAIT;
        end
        S_TXWAIT: if (tx_done_q) begin
          cnt_q <= cnt_q + 9'h001;
          case (cmd_q)
            `CMD_READ_STATUS: state_q <= (cnt_q == `STATUS_BYTES - 9'h001) ? S_CMD : S_NEXT;
            `CMD_VERSION:     state_q <= (cnt_q == `VERSION_BYTES - 9'h001) ? S_CMD : S_NEXT;
            default:          state_q <= (cnt_q == `PAGE_BYTES - 9'h001) ? S_CMD : S_NEXT;
          endcase
        end
        default: state_q <= S_CMD;
      endcase
    end
  end

  // Output drive
  assign o_txd                 = txd_q;
  assign o_handshake_wait_line = busy_q;
  assign o_mem_addr            = mem_addr_q;
  assign o_mem_boot_sel        = mem_boot_q;
  assign o_mem_rd              = mem_rd_q;
  assign o_mem_wr              = mem_wr_q;
  assign o_mem_wdata           = mem_wdata_q;
  assign o_page_commit         = commit_q;
  assign o_erase_start         = erase_start_q;
  assign o_ram_wr              = ram_wr_q;
  assign o_ram_addr            = ram_addr_q - 16'h0001;
  assign o_ram_wdata           = ram_wdata_q;
  assign o_run_download        = run_q;
  assign o_flash_op_status     = flash_op_status;
  assign o_link_check_status   = link_check_status;
endmodule // serial_flash_boot_command_decoder
`default_nettype wire

// >>> design/sfb_cmd_regs.vh
// Constants for the serial boot command decoder
`ifndef SFB_CMD_REGS_VH
`define SFB_CMD_REGS_VH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define CMD_PAGE_READ     8'hFF
`define CMD_PAGE_PROG     8'h41
`define CMD_ERASE_ALL     8'hA7
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_ID_CHECK      8'hF5
`define CMD_DOWNLOAD      8'hFA
`define CMD_VERSION       8'hFB
`define CMD_BOOT_READ     8'hFC

// ------------------------------------------------------------
// Transfer lengths
// ------------------------------------------------------------
`define BYTE_BITS         4'h8
`define PAGE_BYTES        9'h100
`define VERSION_BYTES     9'h008
`define STATUS_BYTES      9'h002
`define HDR_LEN_ADDR      3'h2
`define HDR_LEN_DOWNLOAD  3'h3
`define HDR_LEN_ID        3'h4

// ------------------------------------------------------------
// Status fields and reset values
// ------------------------------------------------------------
`define FLASH_STATUS_RST  8'h80
`define LINK_STATUS_RST   8'h00
`define ID_NOT_VERIFIED   2'h0
`define ID_MISMATCH       2'h1
`define ID_VERIFIED       2'h3

`endif

// >>> verification/sfb_decoder_chk.sv
// Assertion checker for the serial boot command decoder
`timescale 1ns/100ps
`default_nettype none
module sfb_decoder_chk (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_sclk,
  input wire logic       i_flash_blank,
  input wire logic       i_flash_done,
  input wire logic       i_flash_err,
  input wire logic       o_handshake_wait_line,
  input wire logic       o_mem_wr,
  input wire logic       o_page_commit,
  input wire logic       o_erase_start,
  input wire logic       o_ram_wr,
  input wire logic       o_run_download,
  input wire logic [7:0] o_flash_op_status,
  input wire logic [7:0] o_link_check_status
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Guarded commands barred; flash operation in progress
  wire locked     = !i_flash_blank && (o_link_check_status[3:2] != 2'h3);
  wire flash_wait = o_handshake_wait_line && !o_flash_op_status[7];

  // ----------
  // Properties
  // ----------
  chk_reset_vals: assert property ($rose(i_reset_n) |-> o_flash_op_status == 8'h80 && !o_handshake_wait_line)
    else $error("status or busy wrong after reset");
  chk_commit_wr: assert property (o_page_commit |-> o_mem_wr)
    else $error("page commit without last write");
  chk_locked_ops: assert property (locked |-> !(o_erase_start || o_mem_wr || o_ram_wr || o_run_download))
    else $error("flash or ram action while locked");
  chk_op_wait: assert property ((o_erase_start || o_page_commit) |-> ##[1:2] flash_wait)
    else $error("no busy wait after flash start");
  chk_wait_hold: assert property (flash_wait && !i_flash_done && !$past(i_flash_done)
    && !$past(i_flash_done, 2) |=> o_handshake_wait_line)
    else $error("busy dropped before flash done");
  chk_done_release: assert property (flash_wait && i_flash_done
    |-> ##[1:4] (!o_handshake_wait_line && o_flash_op_status[7]))
    else $error("busy not released after flash done");
  chk_err_latch: assert property (flash_wait && i_flash_done && i_flash_err
    |-> ##[1:2] (o_flash_op_status[5:4] != 2'h0))
    else $error("flash error not latched");
  chk_run_csum: assert property (o_run_download |-> ##[0:2] (o_link_check_status[7] && o_link_check_status[4]))
    else $error("run without checksum match");
  chk_busy_rx: assert property ($rose(i_sclk) && !o_handshake_wait_line |-> ##[1:8] o_handshake_wait_line)
    else $error("busy not raised on transfer");
  // Main scenarios reached
  cov_commit: cover property (o_page_commit);
  cov_erase: cover property (o_erase_start && i_flash_blank);
  cov_run: cover property (o_run_download);
endmodule // sfb_decoder_chk
bind serial_flash_boot_command_decoder sfb_decoder_chk u_chk (
  .i_clk, .i_reset_n, .i_sclk, .i_flash_blank, .i_flash_done, .i_flash_err, .o_handshake_wait_line,
  .o_mem_wr, .o_page_commit, .o_erase_start, .o_ram_wr, .o_run_download, .o_flash_op_status,
  .o_link_check_status);
`default_nettype wire

// >>> verification/sfb_programmer_model.sv
// Behavioural serial programmer on the far side of the link
`timescale 1ns/100ps
`default_nettype none
module sfb_programmer_model (
  input  wire logic       i_clk,
  input  wire logic       i_txd,
  input  wire logic       i_busy,
  output var  logic       o_sclk,
  output var  logic       o_rxd,
  output var  logic       o_rx_valid,
  output var  logic [7:0] o_rx_byte
);
  // Idle link, clock parked high
  initial begin
    o_sclk = 1'b1;
    o_rxd = 1'b1;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
  end

  // One byte each way once the device is ready
  task automatic xfer(input logic [7:0] tx, input logic keep);
    int n;
    logic [7:0] rx;
    n = 0;
    @(negedge i_clk);
    while (i_busy !== 1'b0 && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
    for (int b = 0; b < 8; b++) begin
      @(posedge i_clk);
      o_sclk <= 1'b0;
      o_rxd <= tx[b];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (3) @(posedge i_clk);
      rx[b] = i_txd;
    end
    o_rx_byte <= rx;
    o_rxd <= ~tx[7];
    o_rx_valid <= keep;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
endmodule // sfb_programmer_model
`default_nettype wire

// >>> verification/serial_flash_boot_command_decoder_tb.sv
// Self-checking bench for the serial boot command decoder
`timescale 1ns/100ps
`default_nettype none
module serial_flash_boot_command_decoder_tb;
  localparam logic [63:0] VER = "TB_VER_1"; // Arbitrary text
  logic        i_clk, i_reset_n, i_flash_blank, i_mem_wr_ready, i_flash_done, i_flash_err, err_sel;
  logic [7:0]  i_mem_rdata;
  wire         sclk, rxd, o_txd, busy, rx_valid, o_mem_boot_sel, o_mem_rd, o_mem_wr;
  wire         o_page_commit, o_erase_start, o_ram_wr, o_run_download;
  wire  [7:0]  rx_byte, o_mem_wdata, o_ram_wdata, o_flash_op_status, o_link_check_status;
  wire  [15:0] o_mem_addr, o_ram_addr;
  logic [7:0]  exp_rx[$];
  logic [23:0] exp_wr[$], exp_ram[$];
  logic [31:0] rng, stall_s;
  logic [7:0]  lock_cmds[8] = '{8'hFF, 8'h41, 8'hFC, 8'hFA, 8'h50, 8'hA7, 8'hD0, 8'h12};
  int          n_errors, cmp_count, n_erase, n_run, n_cyc, fl_cnt, hold_n, n_rd;

  serial_flash_boot_command_decoder #(.VERSION_TEXT(VER), .FIFO_DEPTH(8)) i_dut (
    .i_clk, .i_reset_n, .i_sclk(sclk), .i_rxd(rxd), .o_txd, .o_handshake_wait_line(busy),
    .i_flash_blank, .o_mem_addr, .o_mem_boot_sel, .o_mem_rd, .i_mem_rdata, .o_mem_wr, .o_mem_wdata,
    .i_mem_wr_ready, .o_page_commit, .o_erase_start, .i_flash_done, .i_flash_err, .o_ram_wr,
    .o_ram_addr, .o_ram_wdata, .o_run_download, .o_flash_op_status, .o_link_check_status);
  sfb_programmer_model u_prog (.i_clk, .i_txd(o_txd), .i_busy(busy), .o_sclk(sclk), .o_rxd(rxd),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));

  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] mem_f(input logic [15:0] a, input logic boot);
    return a[7:0] ^ a[15:8] ^ {boot, 7'h5A};
  endfunction
  // Far-side memory answers in the cycle its address stands
  assign i_mem_rdata = mem_f(o_mem_addr, o_mem_boot_sel);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] b);
    u_prog.xfer(b, 1'b0);
  endtask
  task automatic get(input logic [7:0] e);
    exp_rx.push_back(e);
    u_prog.xfer(8'hFF, 1'b1);
  endtask
  task automatic stat(input logic [7:0] s, input logic [7:0] l);
    send(8'h70);
    get(s);
    get(l);
  endtask
  task automatic idchk(input logic [7:0] bad);
    send(8'hF5);
    send(8'hF0);
    send(8'h12);
    send(8'h00);
    send(8'h07);
    for (int k = 0; k < 7; k++) send(mem_f({8'h12, 8'hF0 + k[7:0]}, 1'b0) ^ bad);
  endtask
  task automatic dl(input logic [7:0] skew);
    logic [7:0] d[4];
    logic [7:0] sum;
    sum = 8'h00;
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      d[k] = rng[7:0];
      sum += d[k];
      exp_ram.push_back({k[15:0], d[k]});
    end
    send(8'hFA);
    send(8'h04);
    send(8'h00);
    send(sum + skew);
    foreach (d[k]) send(d[k]);
  endtask

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Far-side memory and flash timing, result checks, timeout
  always @(posedge i_clk) begin
    n_cyc++;
    stall_s = xs(stall_s);
    i_mem_wr_ready <= (hold_n == 0) && (stall_s[1:0] != 2'h0);
    if (hold_n > 0) hold_n--;
    fl_cnt <= (o_page_commit || o_erase_start) ? 20 : ((fl_cnt > 0) ? fl_cnt - 1 : 0);
    i_flash_done <= (fl_cnt == 1);
    i_flash_err <= err_sel;
    if (rx_valid) check(rx_byte, exp_rx.pop_front());
    if (o_mem_wr) check({o_mem_addr, o_mem_wdata}, exp_wr.pop_front());
    if (o_ram_wr) check({o_ram_addr, o_ram_wdata}, exp_ram.pop_front());
    if (o_erase_start) n_erase++;
    if (o_run_download) n_run++;
    if (o_mem_rd) n_rd++;
    if (n_cyc > 95000) begin
      n_errors++;
      end_of_test;
    end
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    rng = 52;
    stall_s = 52;
    i_reset_n = 1'b0;
    i_flash_blank = 1'b0;
    i_mem_wr_ready = 1'b1;
    i_flash_done = 1'b0;
    i_flash_err = 1'b0;
    err_sel = 1'b0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    stat(8'h80, 8'h00);
    // Locked device drops guarded and unknown commands
    foreach (lock_cmds[k]) send(lock_cmds[k]);
    stat(8'h80, 8'h00);
    send(8'hFB);
    for (int k = 0; k < 8; k++) get(VER[63-8*k -: 8]);
    // Blank flash takes erase; a bad confirm drops both bytes
    i_flash_blank <= 1'b1;
    send(8'hA7);
    send(8'h00);
    send(8'hA7);
    send(8'hD0);
    stat(8'h80, 8'h00);
    i_flash_blank <= 1'b0;
    check(n_erase, 1);
    idchk(8'h01);
    stat(8'h80, 8'h04);
    idchk(8'h00);
    stat(8'h80, 8'h0C);
    // Erase ending in error, then clear
    err_sel = 1'b1;
    send(8'hA7);
    send(8'hD0);
    stat(8'hA0, 8'h0C);
    check(n_erase, 2);
    send(8'h50);
    stat(8'h80, 8'h0C);
    // Page program with a long write stall filling the FIFO
    send(8'h41);
    send(8'h34);
    send(8'h00);
    for (int k = 0; k < 256; k++) begin
      rng = xs(rng);
      if (k == 100) hold_n = 1500;
      exp_wr.push_back({8'h34, k[7:0], rng[7:0]});
      send(rng[7:0]);
    end
    stat(8'h90, 8'h0C);
    send(8'h50);
    dl(8'h01);
    dl(8'h00);
    stat(8'h80, 8'h9C);
    check(n_run, 1);
    // Flash page and boot area page readouts
    for (int c = 0; c < 2; c++) begin
      send(c[0] ? 8'hFC : 8'hFF);
      send(8'h5B);
      send(8'h00);
      for (int k = 0; k < 256; k++) get(mem_f({8'h5B, k[7:0]}, c[0]));
    end
    repeat (20) @(posedge i_clk);
    check(exp_rx.size() + exp_wr.size() + exp_ram.size(), 0);
    check(n_rd, 526);
    end_of_test;
  end
endmodule // serial_flash_boot_command_decoder_tb
`default_nettype wire
